// >>> design/sbrl_regs.svh
// Constants for the serial boot record loader: offsets, codes and timing counts
`ifndef SBRL_REGS_SVH
`define SBRL_REGS_SVH

// ----------------------------------------------------------------------
// Boot ROM window
// ----------------------------------------------------------------------
`define SBRL_ROM_BASE       32'h0000_0000
`define SBRL_ROM_LENGTH     32'h0000_2000

// ----------------------------------------------------------------------
// Serial boot record layout and codes
// ----------------------------------------------------------------------
`define SBRL_SYNC_BYTE      8'h55
`define SBRL_HDR_CMD_OFS    4'h1
`define SBRL_HDR_ADDR_OFS   4'h2
`define SBRL_HDR_COUNT_OFS  4'h6
`define SBRL_HDR_DATA_OFS   4'hA
`define SBRL_CMD_STORE      4'h1
`define SBRL_CMD_EXEC       4'h3
`define SBRL_SIZE_BYTE      4'h1
`define SBRL_SIZE_WORD      4'h2
`define SBRL_SIZE_LONG      4'h4

// ----------------------------------------------------------------------
// Disk boot record layout
// ----------------------------------------------------------------------
`define SBRL_IDE_LOAD_OFS   4'h0
`define SBRL_IDE_EXEC_OFS   4'h4
`define SBRL_IDE_CRC_OFS    4'h8
`define SBRL_IDE_SECT_OFS   4'hA
`define SBRL_IDE_DATA_OFS   4'hC
`define SBRL_IDE_SECT_SHIFT 9
`define SBRL_IDE_MAX_SECT   16'h0100
`define SBRL_IDE_LAST_FILE  2'h2
`define SBRL_CRC_POLY       16'h1021
`define SBRL_CRC_INIT       16'hFFFF

// ----------------------------------------------------------------------
// Serial clock timing
// ----------------------------------------------------------------------
`define SBRL_REF_CLK_HZ     33868800
`define SBRL_SCLK_HZ        100000
`define SBRL_SCLK_HALF_DIV  (`SBRL_REF_CLK_HZ / (2 * `SBRL_SCLK_HZ))

`endif

// >>> design/sbrl_pkg.sv
// Types shared by the serial boot record loader
package sbrl_pkg;

	// ------------------------------------------------------------------
	// Boot source selected by the three select lines
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		SBRL_SRC_SERIAL_MASTER,
		SBRL_SRC_SPI_MASTER,
		SBRL_SRC_IDE_MASTER,
		SBRL_SRC_SERIAL_SLAVE,
		SBRL_SRC_UNUSED,
		SBRL_SRC_UART_GROUP_A,
		SBRL_SRC_UART_GROUP_B,
		SBRL_SRC_UART_GROUP_C
	} sbrl_source_type;

	// ------------------------------------------------------------------
	// Loader sequencer states
	// ------------------------------------------------------------------
	typedef enum {
		ST_INIT, ST_EXTERNAL, ST_HUNT, ST_HDR, ST_DATA, ST_EXEC,
		ST_IDE_HDR, ST_IDE_DATA, ST_IDE_CHECK, ST_DONE, ST_FAIL
	} sbrl_state_type;

	// One memory store: address, right-aligned data, size code
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
		logic [3:0]  size;
	} sbrl_write_type;

endpackage : sbrl_pkg

// >>> design/sbrl_loader.sv
// Serial boot record loader with its input byte FIFO
`timescale 1ns/1ps
`include "sbrl_regs.svh"

// ----------------------------------------------------------------------
// Byte FIFO between the boot link and the record parser
// ----------------------------------------------------------------------
module sbrl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];     // Storage words
	logic [AW-1:0]    wr_ptr;          // Next slot to fill
	logic [AW-1:0]    rd_ptr;          // Next slot to drain
	logic [AW:0]      count;           // Words held
	wire              push = in_valid & in_ready;
	wire              pop  = out_valid & out_ready;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];

	// Storage has no reset, only the pointers and count need one
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// Pointers wrap at DEPTH, which must be a power of two
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count  <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sbrl_fifo

// Operation
// - Strap high: boot ROM out of map
// - Strap low: primary select routes to ROM
// - ROM boot: shared pin acts as alternate select
// - ROM occupies 8 KB from address zero
// - Sample three select lines after initialization
// - Master mode: device drives, no error recovery; disk boot here still tries the next file on CRC failure
// - Slave mode: store received code, then execute
// - Serial clock divides input clock proportionally
// - Three UART baud groups offered
// - Discard bytes through first sync byte
// - Header: command, address, count, then payload
// - Upper nibble command, lower nibble width
// - Command 1 stores, command 3 executes
// - Size 1 byte, 2 word, 4 longword
// - Units go to consecutive addresses
// - After count bytes, next record begins
// - Write each unit once fully received
// - Execute calls address, then parsing resumes
// - Disk header: load, exec, CRC, sectors
// - Disk length in sectors; check CRC first
// - On CRC failure try next boot file
module serial_boot_record_loader (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      boot_source_strap,
	input  wire logic                      boot_type_sel_bit0,
	input  wire logic                      boot_type_sel_bit1,
	input  wire logic                      boot_type_sel_bit2,
	input  wire logic [31:0]               cpu_addr,
	output logic                           rom_mapped,
	output logic                           rom_hit,
	output logic                           primary_chip_select_rom,
	output logic                           alternate_chip_select_mode,
	output sbrl_pkg::sbrl_source_type      boot_source,
	output logic                           master_mode,
	output logic                           slave_mode,
	output logic [1:0]                     uart_baud_group,
	output logic                           serial_clk,
	input  wire logic                      link_valid,
	output logic                           link_ready,
	input  wire logic [7:0]                link_data,
	output sbrl_pkg::sbrl_write_type       mem_wr,
	input  wire logic                      mem_wr_ready,
	output logic                           exec_req,
	output logic [31:0]                    exec_addr,
	input  wire logic                      exec_done,
	output logic [1:0]                     ide_file_index,
	output logic                           ide_file_start,
	output logic                           boot_failed
);
	import sbrl_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Bytes per unit for a size code; unknown codes store bytes
	function automatic logic [2:0] unit_bytes(input logic [3:0] size);
		case (size)
			`SBRL_SIZE_WORD: unit_bytes = 3'h2;
			`SBRL_SIZE_LONG: unit_bytes = 3'h4;
			default:         unit_bytes = 3'h1;
		endcase
	endfunction : unit_bytes

	// CRC over one byte, MSB first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {b, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ((r << 1) ^ `SBRL_CRC_POLY) : (r << 1);
		crc_byte = r;
	endfunction : crc_byte

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	sbrl_state_type state;             // Sequencer state
	logic           strap_high;        // Strap caught after reset release
	logic [3:0]     hdr_idx;           // Header byte index
	logic [3:0]     cmd;               // Record command nibble
	logic [3:0]     size_code;         // Record width nibble
	logic [31:0]    dest_addr;         // Next store address
	logic [31:0]    byte_left;         // Payload bytes still to come
	logic [31:0]    unit_buf;          // Unit being assembled
	logic [2:0]     unit_have;         // Bytes in unit_buf
	logic [15:0]    crc_calc;          // Running disk CRC
	logic [15:0]    crc_want;          // CRC from disk header
	logic [15:0]    sectors;           // Sector count from disk header
	logic [8:0]     sclk_cnt;          // Serial clock half-period count

	// ------------------------------------------------------------------
	// Byte path
	// ------------------------------------------------------------------
	wire        f_valid;               // FIFO holds a byte
	wire [7:0]  f_data;                // Oldest byte
	wire        hdr_state = (state == ST_HUNT) | (state == ST_HDR) | (state == ST_IDE_HDR);
	wire        data_state = (state == ST_DATA) | (state == ST_IDE_DATA);
	// Disk count load cycle: a byte popped here would be lost
	wire        ide_load = (state == ST_IDE_DATA) & (byte_left == 32'h0) & (hdr_idx != 4'h0);
	// Stores stall the parser, which backs up the FIFO and the link
	wire        f_ready = hdr_state | (data_state & ~mem_wr.valid & ~ide_load);
	wire        take = f_valid & f_ready;
	wire [2:0]  width = unit_bytes(size_code);
	wire [2:0]  have_next = unit_have + 3'h1;
	wire        last_byte = (byte_left == 32'h1);
	wire        is_store = (cmd == `SBRL_CMD_STORE);
	wire        unit_done = (have_next == width) | last_byte;
	wire [31:0] unit_word = {unit_buf[23:0], f_data};
	wire [17:0] ide_bytes = {sectors[8:0], 9'h000} - 18'h0000C;
	wire [2:0]  sel = {boot_type_sel_bit2, boot_type_sel_bit1, boot_type_sel_bit0};
	wire        wr_issue = take & (((state == ST_DATA) & is_store & unit_done)
	                       | (state == ST_IDE_DATA));

	sbrl_fifo #(
		.WIDTH (8),
		.DEPTH (8)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (link_valid),
		.in_ready  (link_ready),
		.in_data   (link_data),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_data)
	);

	// ------------------------------------------------------------------
	// Memory map and pin function
	// ------------------------------------------------------------------
	assign rom_mapped                 = (state != ST_INIT) & ~strap_high;
	assign primary_chip_select_rom    = rom_mapped;
	assign alternate_chip_select_mode = rom_mapped;
	assign rom_hit = rom_mapped & (cpu_addr < `SBRL_ROM_BASE + `SBRL_ROM_LENGTH);
	assign master_mode = (boot_source == SBRL_SRC_SERIAL_MASTER)
	                   | (boot_source == SBRL_SRC_SPI_MASTER)
	                   | (boot_source == SBRL_SRC_IDE_MASTER);
	assign slave_mode  = ~master_mode & (boot_source != SBRL_SRC_UNUSED);
	assign uart_baud_group = boot_source[1:0];
	assign exec_req    = (state == ST_EXEC);

	// ------------------------------------------------------------------
	// Serial clock: fixed divider, so its rate follows the input clock
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_cnt   <= '0;
			serial_clk <= 1'b0;
		end
		else if (sclk_cnt == 9'(`SBRL_SCLK_HALF_DIV - 1))
		begin
			sclk_cnt   <= '0;
			serial_clk <= ~serial_clk;
		end
		else
			sclk_cnt <= sclk_cnt + 9'h001;
	end

	// ------------------------------------------------------------------
	// Store port: held until the memory takes it
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mem_wr <= '0;
		else if (wr_issue)
		begin
			mem_wr.valid <= 1'b1;
			mem_wr.addr  <= dest_addr;
			mem_wr.data  <= (state == ST_IDE_DATA) ? {24'h0, f_data} : unit_word;
			mem_wr.size  <= (state == ST_IDE_DATA) ? `SBRL_SIZE_BYTE : size_code;
		end
		else if (mem_wr_ready)
			mem_wr.valid <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_INIT;  strap_high <= 1'b0;  boot_source <= SBRL_SRC_SERIAL_MASTER;
			hdr_idx <= '0;  cmd <= '0;  size_code <= '0;  dest_addr <= '0;
			byte_left <= '0;  unit_buf <= '0;  unit_have <= '0;  crc_calc <= '0;
			crc_want <= '0;  sectors <= '0;  exec_addr <= '0;  ide_file_index <= '0;
			ide_file_start <= 1'b0;  boot_failed <= 1'b0;
		end
		else
		begin
			ide_file_start <= 1'b0;
			case (state)
				// Straps and select lines are caught after reset release
				ST_INIT:
				begin
					strap_high  <= boot_source_strap;
					boot_source <= sbrl_source_type'(sel);
					hdr_idx     <= '0;
					if (boot_source_strap)
						state <= ST_EXTERNAL;
					else if (sel == 3'h4)
					begin
						state       <= ST_FAIL;
						boot_failed <= 1'b1;
					end
					else if (sel == 3'h2)
					begin
						state          <= ST_IDE_HDR;
						ide_file_start <= 1'b1;
						crc_calc       <= `SBRL_CRC_INIT;
					end
					else
						state <= ST_HUNT;
				end
				// Everything up to and including sync is dropped
				ST_HUNT:
					if (take && f_data == `SBRL_SYNC_BYTE)
					begin
						state   <= ST_HDR;
						hdr_idx <= `SBRL_HDR_CMD_OFS;
					end
				ST_HDR:
					if (take)
					begin
						hdr_idx <= hdr_idx + 4'h1;
						if (hdr_idx == `SBRL_HDR_CMD_OFS)
						begin
							cmd       <= f_data[7:4];
							size_code <= f_data[3:0];
						end
						else if (hdr_idx < `SBRL_HDR_COUNT_OFS)
							dest_addr <= {dest_addr[23:0], f_data};
						else
							byte_left <= {byte_left[23:0], f_data};
						unit_have <= '0;
						unit_buf  <= '0;
						// Last header byte: zero count ends the record at once
						if (hdr_idx == `SBRL_HDR_DATA_OFS - 4'h1)
						begin
							if ({byte_left[23:0], f_data} != 32'h0)
								state <= ST_DATA;
							else if (is_store || cmd != `SBRL_CMD_EXEC)
								state <= ST_HUNT;
							else
							begin
								state     <= ST_EXEC;
								exec_addr <= dest_addr;
							end
						end
					end
				// Payload; unknown commands only count it down
				ST_DATA:
					if (take)
					begin
						byte_left <= byte_left - 32'h1;
						// Cleared per unit so short units come out right aligned
						unit_buf  <= unit_done ? 32'h0 : unit_word;
						unit_have <= unit_done ? 3'h0 : have_next;
						if (is_store && unit_done)
							dest_addr <= dest_addr + 32'(width);
						if (last_byte)
						begin
							if (cmd == `SBRL_CMD_EXEC)
							begin
								state     <= ST_EXEC;
								exec_addr <= dest_addr;
							end
							else
								state <= ST_HUNT;
						end
					end
				// Called routine returns through exec_done
				ST_EXEC:
					if (exec_done)
						state <= (boot_source == SBRL_SRC_IDE_MASTER) ? ST_DONE : ST_HUNT;
				// Disk header, twelve bytes, most significant first
				ST_IDE_HDR:
					if (take)
					begin
						hdr_idx <= hdr_idx + 4'h1;
						if (hdr_idx < `SBRL_IDE_EXEC_OFS)
							dest_addr <= {dest_addr[23:0], f_data};
						else if (hdr_idx < `SBRL_IDE_CRC_OFS)
							exec_addr <= {exec_addr[23:0], f_data};
						else if (hdr_idx < `SBRL_IDE_SECT_OFS)
							crc_want <= {crc_want[7:0], f_data};
						else
							sectors <= {sectors[7:0], f_data};
						if (hdr_idx == `SBRL_IDE_DATA_OFS - 4'h1)
						begin
							// Counts past the limit are clipped to it
							if ({sectors[7:0], f_data} > `SBRL_IDE_MAX_SECT)
								sectors <= `SBRL_IDE_MAX_SECT;
							state <= ST_IDE_DATA;
						end
					end
				// Disk payload, one byte store each, CRC runs alongside
				ST_IDE_DATA:
				begin
					if (byte_left == 32'h0 && hdr_idx != 4'h0)
					begin
						byte_left <= (sectors == 16'h0) ? 32'h0 : 32'(ide_bytes);
						hdr_idx   <= 4'h0;
						if (sectors == 16'h0)
							state <= ST_IDE_CHECK;
					end
					else if (take)
					begin
						byte_left <= byte_left - 32'h1;
						dest_addr <= dest_addr + 32'h1;
						crc_calc  <= crc_byte(crc_calc, f_data);
						if (last_byte)
							state <= ST_IDE_CHECK;
					end
				end
				// Execution only on a good CRC; else the next file
				ST_IDE_CHECK:
					if (crc_calc == crc_want)
						state <= ST_EXEC;
					else if (ide_file_index != `SBRL_IDE_LAST_FILE)
					begin
						ide_file_index <= ide_file_index + 2'h1;
						ide_file_start <= 1'b1;
						crc_calc       <= `SBRL_CRC_INIT;
						byte_left      <= '0;
						state          <= ST_IDE_HDR;
					end
					else
					begin
						state       <= ST_FAIL;
						boot_failed <= 1'b1;
					end
				// No recovery in master mode: failure is final
				ST_EXTERNAL, ST_DONE, ST_FAIL:
					state <= state;
				default:
					state <= ST_FAIL;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_rom_strap_out: assert property (
		(state == ST_INIT && boot_source_strap) |=> !rom_mapped [*3])
		else $error("boot ROM mapped with strap high");
	chk_rom_strap_in: assert property (
		(state == ST_INIT && !boot_source_strap) |=> rom_mapped && alternate_chip_select_mode)
		else $error("boot ROM not mapped with strap low");
	chk_rom_window_top: assert property (
		rom_hit |-> cpu_addr <= 32'h0000_1FFF)
		else $error("ROM hit above its window");
	chk_unused_select: assert property (
		(state == ST_INIT && !boot_source_strap && sel == 3'h4) |=> boot_failed)
		else $error("unused select code not failed");
	chk_sync_discard: assert property (
		(state == ST_HUNT && !(take && f_data == 8'h55)) |=> state == ST_HUNT && !wr_issue)
		else $error("byte before sync not discarded");
	chk_sync_detect: assert property (
		(state == ST_HUNT && take && f_data == 8'h55) |=> state == ST_HDR)
		else $error("sync byte not recognised");
	chk_unit_addr_step: assert property (
		(wr_issue && state == ST_DATA) |=> mem_wr.valid
		&& mem_wr.addr == $past(dest_addr)
		&& dest_addr == $past(dest_addr) + 32'($past(width)))
		else $error("store address not consecutive");
	chk_width_size: assert property (
		(wr_issue && state == ST_DATA) |=> mem_wr.size == $past(size_code))
		else $error("store width differs from size code");
	chk_exec_hold: assert property (
		(exec_req && !exec_done) |=> exec_req && $stable(exec_addr))
		else $error("execute request dropped before return");
	chk_exec_resume: assert property (
		(exec_req && exec_done && boot_source != SBRL_SRC_IDE_MASTER) |=> state == ST_HUNT)
		else $error("parsing did not resume after execute");
	chk_ide_retry: assert property (
		(state == ST_IDE_CHECK && crc_calc != crc_want && ide_file_index != 2'h2)
		|=> ide_file_start && ide_file_index == $past(ide_file_index) + 2'h1)
		else $error("next boot file not tried");
	chk_sclk_period: assert property (
		!$stable(serial_clk) |-> $past(sclk_cnt) == 9'(`SBRL_SCLK_HALF_DIV - 1))
		else $error("serial clock toggled off its period");

	cov_store_write: cover property (wr_issue && state == ST_DATA && width == 3'h4);
	cov_exec_return: cover property (exec_req && exec_done);
	cov_ide_retry: cover property (ide_file_start && ide_file_index == 2'h2);
	cov_fifo_full: cover property (!link_ready && mem_wr.valid);

endmodule : serial_boot_record_loader

// >>> sim/sbrl_partner.sv
// Far-side model: paced byte source, store sink and called-routine stub
`timescale 1ns/1ps
module sbrl_partner (
	input  wire logic                     clk,
	input  wire logic                     link_ready,
	output logic                          link_valid,
	output logic [7:0]                    link_data,
	input  wire sbrl_pkg::sbrl_write_type mem_wr,
	output logic                          mem_wr_ready,
	input  wire logic                     exec_req,
	input  wire logic [31:0]              exec_addr,
	output logic                          exec_done
);
	import sbrl_pkg::*;
	logic [7:0]  src[$];           // Bytes still to send
	logic [67:0] got[$];           // Accepted stores {addr,data,size}
	logic [31:0] calls[$];         // Entry points that were called
	logic        stall = 0;        // Accept stores every other cycle
	logic        hold = 0;         // Refuse every store
	logic        taken = 0;        // Byte taken at the last rising edge
	logic [2:0]  wait_cnt = 3'h0;  // Cycles spent inside the routine
	initial link_valid = 0;
	initial link_data = 8'h00;
	initial mem_wr_ready = 0;
	initial exec_done = 0;
	// Note what crossed at each rising edge
	always @(posedge clk)
	begin
		taken = link_valid && link_ready;
		if (mem_wr.valid && mem_wr_ready)
			got.push_back({mem_wr.addr, mem_wr.data, mem_wr.size});
		if (exec_req && exec_done)
			calls.push_back(exec_addr);
	end
	// Outputs move only after the falling edge, held until taken
	always @(negedge clk)
	begin
		if (taken)
			void'(src.pop_front());
		taken = 0;
		link_valid <= (src.size() != 0);
		// Idle line toggles so a stale byte never looks valid
		link_data <= (src.size() != 0) ? src[0] : ~link_data;
		mem_wr_ready <= hold ? 1'b0 : (stall ? ~mem_wr_ready : 1'b1);
		wait_cnt <= exec_req ? wait_cnt + 3'h1 : 3'h0;
		exec_done <= exec_req && (wait_cnt == 3'h3);
	end
endmodule : sbrl_partner

// >>> sim/tb.sv
// Self-checking bench for the serial boot record loader
`timescale 1ns/1ps
module tb;
	import sbrl_pkg::*;
	logic           clk = 0;
	logic           rst_n = 0;
	logic           strap = 0;
	logic [2:0]     sel = 3'h0;
	logic [31:0]    cpu_addr = 32'h0;
	logic           rom_mapped, rom_hit, cs_rom, alt_cs, master_mode, slave_mode;
	logic           serial_clk, link_valid, link_ready, mem_wr_ready;
	logic           exec_req, exec_done, ide_start, boot_failed;
	logic [1:0]     baud, ide_index;
	logic [7:0]     link_data;
	logic [31:0]    exec_addr;
	sbrl_source_type boot_source;
	sbrl_write_type mem_wr;
	logic [5:0]     rows[8];       // {sel, master, slave, failed}
	logic [67:0]    exp_st[$];     // Expected stores
	int             failures = 0;
	int             num_checks = 0;
	int             cycles = 0;
	int             starts = 0;    // Disk file start pulses seen
	time            t0;
	always #5 clk = ~clk;
	serial_boot_record_loader dut (.clk(clk), .rst_n(rst_n), .boot_source_strap(strap),
		.boot_type_sel_bit0(sel[0]), .boot_type_sel_bit1(sel[1]), .boot_type_sel_bit2(sel[2]),
		.cpu_addr(cpu_addr), .rom_mapped(rom_mapped), .rom_hit(rom_hit),
		.primary_chip_select_rom(cs_rom), .alternate_chip_select_mode(alt_cs),
		.boot_source(boot_source), .master_mode(master_mode), .slave_mode(slave_mode),
		.uart_baud_group(baud), .serial_clk(serial_clk), .link_valid(link_valid),
		.link_ready(link_ready), .link_data(link_data), .mem_wr(mem_wr),
		.mem_wr_ready(mem_wr_ready), .exec_req(exec_req), .exec_addr(exec_addr),
		.exec_done(exec_done), .ide_file_index(ide_index), .ide_file_start(ide_start),
		.boot_failed(boot_failed));
	sbrl_partner p (.clk(clk), .link_ready(link_ready), .link_valid(link_valid),
		.link_data(link_data), .mem_wr(mem_wr), .mem_wr_ready(mem_wr_ready),
		.exec_req(exec_req), .exec_addr(exec_addr), .exec_done(exec_done));
	// Compare one value and count it
	task automatic check(input string name, input logic [71:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : check
	// Reset with the straps held, then let sampling settle
	task automatic do_reset(input logic s, input logic [2:0] code);
		@(negedge clk);
		rst_n = 0;
		strap = s;
		sel = code;
		#1 p.src.delete();
		p.got.delete();
		p.calls.delete();
		starts = 0;
		repeat (3) @(negedge clk);
		rst_n = 1;
		repeat (3) @(negedge clk);
	endtask : do_reset
	// Queue a record header and k payload bytes of d, MSB first
	task automatic rec(input logic [7:0] c, input logic [31:0] a, n, d, input int k);
		logic [79:0] h;
		h = {8'h55, c, a, n};
		for (int i = 9; i >= 0; i--)
			p.src.push_back(h[i*8 +: 8]);
		for (int i = k - 1; i >= 0; i--)
			p.src.push_back(d[i*8 +: 8]);
	endtask : rec
	// Queue a disk header with no sectors, MSB first
	task automatic ide_img(input logic [15:0] crc);
		logic [95:0] h;
		h = {32'h7000, 32'h8000, crc, 16'h0};
		for (int i = 11; i >= 0; i--)
			p.src.push_back(h[i*8 +: 8]);
	endtask : ide_img
	// Wait for the source to drain, bounded
	task automatic drain();
		for (int n = 0; n < 600 && p.src.size() != 0; n++)
			@(negedge clk);
		repeat (40) @(negedge clk);
	endtask : drain
	task automatic summarize();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// Count disk file starts; cut a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (ide_start === 1'b1)
			starts++;
		if (cycles == 8000)
		begin
			failures++;
			summarize();
		end
	end
	initial
	begin
		rows = '{6'b000_100, 6'b001_100, 6'b010_100, 6'b011_010,
			6'b100_001, 6'b101_010, 6'b110_010, 6'b111_010};
		foreach (rows[i])
		begin
			do_reset(1'b0, rows[i][5:3]);
			check("boot_source", boot_source, rows[i][5:3]);
			check("master_mode", master_mode, rows[i][2]);
			check("slave_mode", slave_mode, rows[i][1]);
			check("boot_failed", boot_failed, rows[i][0]);
			check("baud_group", baud, rows[i][4:3]);
			check("cs_rom", {cs_rom, alt_cs, rom_mapped}, 3'h7);
		end
		cpu_addr = 32'h0000_1FFF;
		#1 check("rom_hit_top", rom_hit, 1'b1);
		cpu_addr = 32'h0000_2000;
		#1 check("rom_hit_past", rom_hit, 1'b0);
		@(posedge serial_clk);
		t0 = $time;
		@(posedge serial_clk);
		check("sclk_period", ($time - t0) / 10, 338);
		do_reset(1'b1, 3'h3);
		cpu_addr = 32'h0;
		#1 check("ext_boot", {rom_mapped, rom_hit, cs_rom, alt_cs}, 4'h0);
		do_reset(1'b0, 3'h3);
		// Slave stream; stores refused first so the byte buffer fills
		p.hold = 1;
		p.src.push_back(8'h00);
		p.src.push_back(8'hAA);
		rec(8'h14, 32'h1000, 32'h6, 32'hAABBCCDD, 4);
		p.src.push_back(8'h11);
		p.src.push_back(8'h22);
		rec(8'h12, 32'h2000, 32'h4, 32'h01020304, 4);
		rec(8'h11, 32'h3000, 32'h1, 32'h77, 1);
		rec(8'h51, 32'h0, 32'h2, 32'h5555, 2);
		rec(8'h31, 32'h4000, 32'h0, 32'h0, 0);
		rec(8'h11, 32'h5000, 32'h0, 32'h0, 0);
		rec(8'h11, 32'h6000, 32'h1, 32'h88, 1);
		for (int n = 0; n < 50 && link_ready !== 1'b0; n++)
			@(negedge clk);
		check("fifo_full", link_ready, 1'b0);
		p.hold = 0;
		p.stall = 1;
		drain();
		exp_st = '{{32'h1000, 32'hAABBCCDD, 4'h4}, {32'h1004, 32'h1122, 4'h4},
			{32'h2000, 32'h0102, 4'h2}, {32'h2002, 32'h0304, 4'h2},
			{32'h3000, 32'h77, 4'h1}, {32'h6000, 32'h88, 4'h1}};
		check("store_count", p.got.size(), 6);
		foreach (exp_st[i])
			check("store", p.got[i], exp_st[i]);
		check("exec_call", p.calls[0], 32'h4000);
		// Disk boot: good empty image, then three bad ones
		do_reset(1'b0, 3'h2);
		ide_img(16'hFFFF);
		drain();
		check("ide_exec", p.calls[0], 32'h8000);
		do_reset(1'b0, 3'h2);
		repeat (3)
			ide_img(16'h1234);
		drain();
		check("ide_fail", {boot_failed, ide_index, p.calls.size()}, 35'h6_0000_0000);
		check("ide_starts", starts, 3);
		summarize();
	end
endmodule : tb
